/* core/uart_channel_reset_state.sv */
// One UART channel register file with reset state and receive event timing
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// R1: Reset loads the divisor low byte with 01 and clears the high and fraction bytes.
// R2: Reset makes the interrupt source register read 01, no interrupt pending.
// R3: Reset makes the line status read 60, holding and transmitter empty.
// R4: Reset fills the scratchpad with FF.
// R5: Reset clears the low modem status nibble; the high nibble shows the modem inputs.
// R6: Reset clears interrupt enable, FIFO, line, modem, feature and enhanced registers.
// R7: Reset clears FIFO counts and triggers, flow status and the four flow characters.
// R8: Receive and transmit holding contents are undefined after reset.
// R9: Serial output idles high and infrared output low during and after reset.
// R10: Both active-low modem outputs are high during and after reset.
// R11: The receive interrupt rises within one baud clock after the stop bit.
// R12: The baud clock runs at 16, 8 or 4 times the bit rate by sampling mode.
// R13: Reset clears every enhanced function bit for legacy behaviour.
// R14: Flow status is cleared whenever software flow control is off.
// R15: Reset values apply per channel while the reset input is high.
module uart_channel_reset_state (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// Register port
	input wire logic [4:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Receive side events from the channel datapath
	input wire logic i_rx_stop_done,
	input wire logic [7:0] i_rx_char,
	input wire logic [3:0] i_flow_events,
	// Modem inputs, active low pins, bits 3..0 are cd, ri, dsr, cts
	input wire logic [3:0] i_modem_n,
	// Serial and modem outputs
	output logic o_serial_tx,
	output logic o_infrared_transmit_out,
	output logic o_rts_n,
	output logic o_dtr_n,
	// Interrupt and baud enables
	output logic o_irq,
	output logic o_bclk_tick,
	output logic o_bit_tick
);
	logic [7:0] div_low_r, div_low_nxt, div_high_r, div_high_nxt, div_frac_r, div_frac_nxt;
	logic [7:0] ier_r, ier_nxt, fcr_r, fcr_nxt, lcr_r, lcr_nxt, mcr_r, mcr_nxt;
	logic [7:0] spr_r, spr_nxt, feature_control_reg_r, feature_control_reg_nxt, efr_r, efr_nxt;
	logic [7:0] tx_fifo_trigger_r, tx_fifo_trigger_nxt, rx_fifo_trigger_r, rx_fifo_trigger_nxt;
	logic [7:0] tx_fifo_count_r, rx_fifo_count_r, flow_r, flow_nxt;
	logic [7:0] res1_r, res1_nxt, res2_r, res2_nxt, pau1_r, pau1_nxt, pau2_r, pau2_nxt;
	logic [7:0] rx_hold_r, rx_hold_nxt;
	logic [3:0] msr_low_r, msr_low_nxt;
	logic [1:0] ist_r, ist_nxt, imask_r, imask_nxt;
	logic [1:0] smp_r, smp_nxt;
	logic data_ready_r, data_ready_nxt;
	logic rx_pend_r, rx_pend_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [3:0] modem_s1_r, modem_s2_r, modem_prev_r;
	logic stop_s1_r, stop_s2_r, stop_prev_r;
	logic stop_edge, enh_wr, sw_flow_off;
	logic [7:0] isr_val, lsr_val, msr_val;
	logic bclk, bitt;

	// Baud enable divider
	baud_tick_gen u_baud (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_divisor({div_high_r, div_low_r}),
		.i_fraction(div_frac_r[3:0]),
		.i_sample_mode(smp_r),
		.o_bclk_tick(bclk),
		.o_bit_tick(bitt)
	);
	assign o_bclk_tick = bclk;
	assign o_bit_tick = bitt;

	// Pin synchronisers; first stage read only by the second
	always_ff @(posedge i_sys_clk) begin
		modem_s1_r <= i_modem_n;
		modem_s2_r <= modem_s1_r;
		stop_s1_r <= i_rx_stop_done;
		stop_s2_r <= stop_s1_r;
		if (i_reset) begin
			// Track the pins in reset so no false delta follows release; see R5
			modem_prev_r <= ~modem_s2_r;
			stop_prev_r <= 1'b0;
		end else begin
			modem_prev_r <= ~modem_s2_r;
			stop_prev_r <= stop_s2_r;
		end
	end
	assign stop_edge = stop_s2_r & ~stop_prev_r;

	// Enhanced bits change only while the enable bit is set
	assign enh_wr = efr_r[uart_chan_pkg::EFR_ENH_BIT];
	assign sw_flow_off = (efr_r[3:0] == 4'h0);

	// Composite read values
	assign isr_val = rx_pend_r ? 8'h04 : uart_chan_pkg::INT_SRC_NONE; // see R2
	assign lsr_val = {1'b0, 1'b1, 1'b1, 4'h0, data_ready_r}; // see R3
	assign msr_val = {~modem_s2_r, msr_low_r}; // see R5

	// Register next state
	always_comb begin
		div_low_nxt = div_low_r;
		div_high_nxt = div_high_r;
		div_frac_nxt = div_frac_r;
		ier_nxt = ier_r;
		fcr_nxt = fcr_r;
		lcr_nxt = lcr_r;
		mcr_nxt = mcr_r;
		spr_nxt = spr_r;
		feature_control_reg_nxt = feature_control_reg_r;
		efr_nxt = efr_r;
		tx_fifo_trigger_nxt = tx_fifo_trigger_r;
		rx_fifo_trigger_nxt = rx_fifo_trigger_r;
		res1_nxt = res1_r;
		res2_nxt = res2_r;
		pau1_nxt = pau1_r;
		pau2_nxt = pau2_r;
		smp_nxt = smp_r;
		imask_nxt = imask_r;
		rx_hold_nxt = rx_hold_r;
		flow_nxt = flow_r | {4'h0, i_flow_events};
		msr_low_nxt = msr_low_r | (modem_prev_r ^ ~modem_s2_r);
		data_ready_nxt = data_ready_r;
		rx_pend_nxt = rx_pend_r;
		ist_nxt = ist_r;
		rdata_nxt = 8'h00;
		if (i_wr) begin
			unique case (i_addr)
				uart_chan_pkg::A_IER: ier_nxt = enh_wr ? i_wdata : {ier_r[7:5], i_wdata[4:0]}; // see R13
				uart_chan_pkg::A_FCR_ISR: fcr_nxt = enh_wr ? i_wdata : {i_wdata[7:6], fcr_r[5:4], i_wdata[3:0]};
				uart_chan_pkg::A_LCR: lcr_nxt = i_wdata;
				uart_chan_pkg::A_MCR: mcr_nxt = enh_wr ? i_wdata : {mcr_r[7:5], i_wdata[4], mcr_r[3:2], i_wdata[1:0]};
				uart_chan_pkg::A_SPR: spr_nxt = i_wdata;
				uart_chan_pkg::A_DIV_LOW: div_low_nxt = i_wdata;
				uart_chan_pkg::A_DIV_HIGH: div_high_nxt = i_wdata;
				uart_chan_pkg::A_DIV_FRAC: div_frac_nxt = i_wdata;
				uart_chan_pkg::A_FEATURE_CONTROL_REG: feature_control_reg_nxt = i_wdata;
				uart_chan_pkg::A_EFR: efr_nxt = i_wdata;
				uart_chan_pkg::A_TX_FIFO_TRIGGER: tx_fifo_trigger_nxt = i_wdata;
				uart_chan_pkg::A_RX_FIFO_TRIGGER: rx_fifo_trigger_nxt = i_wdata;
				uart_chan_pkg::A_RES1: res1_nxt = i_wdata;
				uart_chan_pkg::A_RES2: res2_nxt = i_wdata;
				uart_chan_pkg::A_PAU1: pau1_nxt = i_wdata;
				uart_chan_pkg::A_PAU2: pau2_nxt = i_wdata;
				uart_chan_pkg::A_INT_MASK: imask_nxt = i_wdata[1:0];
				uart_chan_pkg::A_SAMPLE: smp_nxt = i_wdata[1:0];
				default: ;
			endcase
		end
		// Write one to clear; new events below win over the clear
		if (i_wr && i_addr == uart_chan_pkg::A_INT_STAT) begin
			ist_nxt = ist_r & ~i_wdata[1:0];
		end
		if (i_rd) begin
			unique case (i_addr)
				uart_chan_pkg::A_RX_TX: rdata_nxt = rx_hold_r;
				uart_chan_pkg::A_IER: rdata_nxt = ier_r;
				uart_chan_pkg::A_FCR_ISR: rdata_nxt = isr_val;
				uart_chan_pkg::A_LCR: rdata_nxt = lcr_r;
				uart_chan_pkg::A_MCR: rdata_nxt = mcr_r;
				uart_chan_pkg::A_LSR: rdata_nxt = lsr_val;
				uart_chan_pkg::A_MSR: rdata_nxt = msr_val;
				uart_chan_pkg::A_SPR: rdata_nxt = spr_r;
				uart_chan_pkg::A_DIV_LOW: rdata_nxt = div_low_r;
				uart_chan_pkg::A_DIV_HIGH: rdata_nxt = div_high_r;
				uart_chan_pkg::A_DIV_FRAC: rdata_nxt = div_frac_r;
				uart_chan_pkg::A_FEATURE_CONTROL_REG: rdata_nxt = feature_control_reg_r;
				uart_chan_pkg::A_EFR: rdata_nxt = efr_r;
				uart_chan_pkg::A_TX_FIFO_COUNT: rdata_nxt = tx_fifo_count_r;
				uart_chan_pkg::A_TX_FIFO_TRIGGER: rdata_nxt = tx_fifo_trigger_r;
				uart_chan_pkg::A_RX_FIFO_COUNT: rdata_nxt = rx_fifo_count_r;
				uart_chan_pkg::A_RX_FIFO_TRIGGER: rdata_nxt = rx_fifo_trigger_r;
				uart_chan_pkg::A_FLOWST: rdata_nxt = flow_r;
				uart_chan_pkg::A_INT_STAT: rdata_nxt = {6'h00, ist_r};
				uart_chan_pkg::A_INT_MASK: rdata_nxt = {6'h00, imask_r};
				uart_chan_pkg::A_SAMPLE: rdata_nxt = {6'h00, smp_r};
				default: rdata_nxt = 8'h00;
			endcase
			// Read clears flow status and modem deltas; events this cycle survive
			if (i_addr == uart_chan_pkg::A_FLOWST) begin
				flow_nxt = {4'h0, i_flow_events};
			end
			if (i_addr == uart_chan_pkg::A_MSR) begin
				msr_low_nxt = modem_prev_r ^ ~modem_s2_r;
			end
			if (i_addr == uart_chan_pkg::A_RX_TX) begin
				data_ready_nxt = 1'b0;
				rx_pend_nxt = 1'b0;
			end
		end
		// Received character; interrupt pending flag loads IER bit 0 at once on the stop edge
		if (stop_edge) begin
			rx_hold_nxt = i_rx_char;
			data_ready_nxt = 1'b1;
			rx_pend_nxt = ier_r[0]; // see R11
			ist_nxt[uart_chan_pkg::EV_RX_BIT] = 1'b1;
		end
		if (i_wr && i_addr == uart_chan_pkg::A_RX_TX) begin
			ist_nxt[uart_chan_pkg::EV_TX_BIT] = 1'b1;
		end
		if (sw_flow_off) begin
			flow_nxt = uart_chan_pkg::ZERO_RST; // see R14
		end
	end

	// Registers; all reset values while the reset input is high
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin // see R15
			div_low_r <= uart_chan_pkg::DIV_LOW_RST; // see R1
			div_high_r <= uart_chan_pkg::DIV_HIGH_RST;
			div_frac_r <= uart_chan_pkg::DIV_FRAC_RST;
			ier_r <= uart_chan_pkg::ZERO_RST; // see R6
			fcr_r <= uart_chan_pkg::ZERO_RST;
			lcr_r <= uart_chan_pkg::ZERO_RST;
			mcr_r <= uart_chan_pkg::ZERO_RST; // see R13
			feature_control_reg_r <= uart_chan_pkg::ZERO_RST;
			efr_r <= uart_chan_pkg::ZERO_RST;
			spr_r <= uart_chan_pkg::SCRATCH_RST; // see R4
			tx_fifo_trigger_r <= uart_chan_pkg::ZERO_RST; // see R7
			rx_fifo_trigger_r <= uart_chan_pkg::ZERO_RST;
			tx_fifo_count_r <= uart_chan_pkg::ZERO_RST;
			rx_fifo_count_r <= uart_chan_pkg::ZERO_RST;
			flow_r <= uart_chan_pkg::ZERO_RST;
			res1_r <= uart_chan_pkg::ZERO_RST;
			res2_r <= uart_chan_pkg::ZERO_RST;
			pau1_r <= uart_chan_pkg::ZERO_RST;
			pau2_r <= uart_chan_pkg::ZERO_RST;
			msr_low_r <= uart_chan_pkg::MSR_LOW_RST; // see R5
			smp_r <= uart_chan_pkg::SMP_16X;
			imask_r <= 2'h0;
			ist_r <= 2'h0;
			data_ready_r <= 1'b0;
			rx_pend_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			div_low_r <= div_low_nxt;
			div_high_r <= div_high_nxt;
			div_frac_r <= div_frac_nxt;
			ier_r <= ier_nxt;
			fcr_r <= fcr_nxt;
			lcr_r <= lcr_nxt;
			mcr_r <= mcr_nxt;
			feature_control_reg_r <= feature_control_reg_nxt;
			efr_r <= efr_nxt;
			spr_r <= spr_nxt;
			tx_fifo_trigger_r <= tx_fifo_trigger_nxt;
			rx_fifo_trigger_r <= rx_fifo_trigger_nxt;
			flow_r <= flow_nxt;
			res1_r <= res1_nxt;
			res2_r <= res2_nxt;
			pau1_r <= pau1_nxt;
			pau2_r <= pau2_nxt;
			msr_low_r <= msr_low_nxt;
			smp_r <= smp_nxt;
			imask_r <= imask_nxt;
			ist_r <= ist_nxt;
			data_ready_r <= data_ready_nxt;
			rx_pend_r <= rx_pend_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Holding register has no reset; its content is undefined afterwards
	always_ff @(posedge i_sys_clk) begin
		rx_hold_r <= rx_hold_nxt; // see R8
	end

	// Outputs; transmit datapath is outside, so line stays at mark here
	assign o_rdata = rdata_r;
	assign o_serial_tx = 1'b1; // see R9
	assign o_infrared_transmit_out = 1'b0;
	assign o_rts_n = ~mcr_r[uart_chan_pkg::MCR_RTS_BIT]; // see R10
	assign o_dtr_n = ~mcr_r[uart_chan_pkg::MCR_DTR_BIT];
	assign o_irq = |(ist_r & imask_r);

	// Checks
	reset_div_a: assert property (@(posedge i_sys_clk) i_reset |=> // see R1
		div_low_r == 8'h01 && div_high_r == 8'h00 && div_frac_r == 8'h00)
		else $error("divisor reset value wrong");
	reset_spr_a: assert property (@(posedge i_sys_clk) i_reset |=> spr_r == 8'hFF) // see R4
		else $error("scratchpad reset value wrong");
	reset_ctl_a: assert property (@(posedge i_sys_clk) i_reset |=> // see R6
		ier_r == 8'h00 && lcr_r == 8'h00 && efr_r == 8'h00 && feature_control_reg_r == 8'h00)
		else $error("control reset value wrong");
	reset_modem_a: assert property (@(posedge i_sys_clk) i_reset |=> // see R10
		o_rts_n && o_dtr_n) else $error("modem outputs not idle");
	idle_line_a: assert property (@(posedge i_sys_clk) // see R9
		o_serial_tx && !o_infrared_transmit_out) else $error("serial line not idle");
	flow_off_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see R14
		sw_flow_off |=> flow_r == 8'h00) else $error("flow status not cleared");
	rx_int_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see R11
		stop_edge && ier_r[0] |=> isr_val == 8'h04 || $past(i_rd))
		else $error("receive interrupt late");
	isr_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see R2
		!rx_pend_r |-> isr_val == 8'h01) else $error("idle source code wrong");
	lsr_empty_a: assert property (@(posedge i_sys_clk) i_reset |=> // see R3
		lsr_val == 8'h60) else $error("line status reset wrong");
endmodule // uart_channel_reset_state

/* core/uart_chan_pkg.sv */
// Package with reset values, register offsets and shared types of one UART channel
package uart_chan_pkg;
	localparam logic [7:0] DIV_LOW_RST = 8'h01;
	localparam logic [7:0] DIV_HIGH_RST = 8'h00;
	localparam logic [7:0] DIV_FRAC_RST = 8'h00;
	localparam logic [7:0] INT_SRC_NONE = 8'h01;
	localparam logic [7:0] LINE_STAT_RST = 8'h60;
	localparam logic [7:0] SCRATCH_RST = 8'hFF;
	localparam logic [7:0] ZERO_RST = 8'h00;
	localparam logic [3:0] MSR_LOW_RST = 4'h0;
	// Register offsets
	localparam logic [4:0] A_RX_TX = 5'h00;
	localparam logic [4:0] A_IER = 5'h01;
	localparam logic [4:0] A_FCR_ISR = 5'h02;
	localparam logic [4:0] A_LCR = 5'h03;
	localparam logic [4:0] A_MCR = 5'h04;
	localparam logic [4:0] A_LSR = 5'h05;
	localparam logic [4:0] A_MSR = 5'h06;
	localparam logic [4:0] A_SPR = 5'h07;
	localparam logic [4:0] A_DIV_LOW = 5'h08;
	localparam logic [4:0] A_DIV_HIGH = 5'h09;
	localparam logic [4:0] A_DIV_FRAC = 5'h0A;
	localparam logic [4:0] A_FEATURE_CONTROL_REG = 5'h0B;
	localparam logic [4:0] A_EFR = 5'h0C;
	localparam logic [4:0] A_TX_FIFO_COUNT = 5'h0D;
	localparam logic [4:0] A_TX_FIFO_TRIGGER = 5'h0E;
	localparam logic [4:0] A_RX_FIFO_COUNT = 5'h0F;
	localparam logic [4:0] A_RX_FIFO_TRIGGER = 5'h10;
	localparam logic [4:0] A_FLOWST = 5'h11;
	localparam logic [4:0] A_RES1 = 5'h12;
	localparam logic [4:0] A_RES2 = 5'h13;
	localparam logic [4:0] A_PAU1 = 5'h14;
	localparam logic [4:0] A_PAU2 = 5'h15;
	localparam logic [4:0] A_INT_STAT = 5'h16;
	localparam logic [4:0] A_INT_MASK = 5'h17;
	localparam logic [4:0] A_SAMPLE = 5'h18;
	// Field positions
	localparam int EFR_ENH_BIT = 4;
	localparam int LSR_THRE_BIT = 5;
	localparam int LSR_TEMT_BIT = 6;
	localparam int LSR_DR_BIT = 0;
	localparam int MCR_DTR_BIT = 0;
	localparam int MCR_RTS_BIT = 1;
	localparam int EV_RX_BIT = 0;
	localparam int EV_TX_BIT = 1;
	// Oversampling ratios selected by the sampling mode code
	localparam logic [1:0] SMP_16X = 2'h0;
	localparam logic [1:0] SMP_8X = 2'h1;
	localparam logic [1:0] SMP_4X = 2'h2;
	localparam logic [4:0] RATIO_16 = 5'h10;
	localparam logic [4:0] RATIO_8 = 5'h08;
	localparam logic [4:0] RATIO_4 = 5'h04;
	// Stop-to-interrupt bound in baud clock periods
	localparam int STOP_INT_BCLK = 1;
	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

/* core/baud_tick_gen.sv */
// Baud clock enable divider with fractional divisor and sampling ratio
`timescale 1ns/1ns
module baud_tick_gen (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// Divisor and mode
	input wire logic [15:0] i_divisor,
	input wire logic [3:0] i_fraction,
	input wire logic [1:0] i_sample_mode,
	// Enables
	output logic o_bclk_tick,
	output logic o_bit_tick
);
	logic [19:0] cnt_r, cnt_nxt;
	logic [4:0] sub_r, sub_nxt;
	logic [4:0] ratio;
	logic [19:0] limit;
	logic tick_r, tick_nxt, bit_r, bit_nxt;

	// Baud clock is 16, 8 or 4 times the bit rate
	always_comb begin
		unique case (i_sample_mode) // see R12
			uart_chan_pkg::SMP_8X: ratio = uart_chan_pkg::RATIO_8;
			uart_chan_pkg::SMP_4X: ratio = uart_chan_pkg::RATIO_4;
			default: ratio = uart_chan_pkg::RATIO_16;
		endcase
	end

	// Divisor of zero behaves as one to keep the tick alive
	assign limit = (i_divisor == 16'h0000) ? 20'h00010 : {i_divisor, i_fraction};

	// Count sixteenths so the fraction stretches the period evenly
	always_comb begin
		cnt_nxt = cnt_r + 20'h00010;
		tick_nxt = 1'b0;
		sub_nxt = sub_r;
		bit_nxt = 1'b0;
		if (cnt_nxt >= limit) begin
			cnt_nxt = cnt_nxt - limit;
			tick_nxt = 1'b1;
			if (sub_r >= ratio - 5'h01) begin
				sub_nxt = 5'h00;
				bit_nxt = 1'b1;
			end else begin
				sub_nxt = sub_r + 5'h01;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			cnt_r <= 20'h00000;
			sub_r <= 5'h00;
			tick_r <= 1'b0;
			bit_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			sub_r <= sub_nxt;
			tick_r <= tick_nxt;
			bit_r <= bit_nxt;
		end
	end

	assign o_bclk_tick = tick_r;
	assign o_bit_tick = bit_r;
endmodule // baud_tick_gen

/* tb/serial_far_end.sv */
// Far end model that drives receive events, flow events and modem pins
`timescale 1ns/1ns
module serial_far_end (
	// Clock
	input wire logic i_sys_clk,
	// Datapath side lines
	output logic o_rx_stop_done,
	output logic [7:0] o_rx_char,
	output logic [3:0] o_flow_events,
	output logic [3:0] o_modem_n
);
	initial begin
		o_rx_stop_done = 1'b0;
		o_rx_char = 8'hA5;
		o_flow_events = 4'h0;
		o_modem_n = 4'hF;
	end
	// Character is set up one cycle before the stop edge, held until end_char
	task automatic send_char(input logic [7:0] c);
		@(posedge i_sys_clk) o_rx_char <= c;
		@(posedge i_sys_clk) o_rx_stop_done <= 1'b1;
	endtask
	// Stale data inverted so a late sample can never match by luck
	task automatic end_char();
		@(posedge i_sys_clk) o_rx_stop_done <= 1'b0;
		o_rx_char <= ~o_rx_char;
	endtask
	// One-cycle flow character events
	task automatic pulse_flow(input logic [3:0] f);
		@(posedge i_sys_clk) o_flow_events <= f;
		@(posedge i_sys_clk) o_flow_events <= 4'h0;
	endtask
	task automatic set_pins(input logic [3:0] p);
		@(posedge i_sys_clk) o_modem_n <= p;
	endtask
endmodule // serial_far_end

/* tb/uart_channel_reset_state_test.sv */
// Self-checking bench for the UART channel register file and event timing
`timescale 1ns/1ns
module uart_channel_reset_state_test;
	// Clock, reset and register port
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [4:0] i_addr = 5'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	// Far end lines and design outputs
	logic stop_done;
	logic [7:0] rx_char;
	logic [3:0] flow_ev;
	logic [3:0] modem_n;
	logic o_serial_tx, o_infrared_transmit_out, o_rts_n, o_dtr_n, o_irq, o_bclk_tick, o_bit_tick;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;
	logic [7:0] c;
	logic [7:0] mdl [0:31];

	initial begin
		forever #4 i_sys_clk = ~i_sys_clk;
	end

	uart_channel_reset_state dut (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_stop_done(stop_done),
		.i_rx_char(rx_char), .i_flow_events(flow_ev), .i_modem_n(modem_n),
		.o_serial_tx(o_serial_tx), .o_infrared_transmit_out(o_infrared_transmit_out),
		.o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n), .o_irq(o_irq), .o_bclk_tick(o_bclk_tick),
		.o_bit_tick(o_bit_tick));

	serial_far_end far (
		.i_sys_clk(i_sys_clk), .o_rx_stop_done(stop_done), .o_rx_char(rx_char),
		.o_flow_events(flow_ev), .o_modem_n(modem_n));

	// Cut a hang short; the run needs a few hundred cycles
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end

	// Reset values of readable registers; offset 00 is left out, its contents are undefined
	function automatic logic [7:0] rst_val(input logic [4:0] a);
		case (a)
			uart_chan_pkg::A_DIV_LOW: return 8'h01;
			uart_chan_pkg::A_FCR_ISR: return 8'h01;
			uart_chan_pkg::A_LSR: return 8'h60;
			uart_chan_pkg::A_SPR: return 8'hFF;
			uart_chan_pkg::A_MSR: return {~modem_n, 4'h0};
			default: return 8'h00;
		endcase
	endfunction

	task automatic check(input logic [7:0] g, input logic [7:0] e, input string m);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_sys_clk) begin
			i_wr <= 1'b1;
			i_addr <= a;
			i_wdata <= d;
		end
		@(posedge i_sys_clk) i_wr <= 1'b0;
		mdl[a] = d;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [7:0] g);
		@(posedge i_sys_clk) begin
			i_rd <= 1'b1;
			i_addr <= a;
		end
		@(posedge i_sys_clk) i_rd <= 1'b0;
		#1 g = o_rdata;
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] g;
		rd(a, g);
		check(g, e, $sformatf("read of %h", a));
	endtask

	task automatic table_chk();
		for (int a = 1; a < 25; a++) begin
			rd_chk(5'(a), rst_val(5'(a)));
		end
		rd_chk(5'h1F, 8'h00);
	endtask

	task automatic do_reset();
		@(posedge i_sys_clk) i_reset <= 1'b1;
		repeat (12) @(posedge i_sys_clk);
		#1 check({4'h0, o_serial_tx, o_infrared_transmit_out, o_rts_n, o_dtr_n}, 8'h0B, "pins in reset");
		@(posedge i_sys_clk) i_reset <= 1'b0;
		#1 check({4'h0, o_serial_tx, o_infrared_transmit_out, o_rts_n, o_dtr_n}, 8'h0B, "pins after reset");
		for (int a = 0; a < 32; a++) mdl[a] = rst_val(5'(a));
	endtask

	// Counter of mismatches and checks, then the verdict
	task automatic close_out();
		$display("Checks made %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(68708));
		far.set_pins(4'($urandom));
		do_reset();
		table_chk();
		$display("Test finished: reset values");
		// Random contents must be thrown away by a second reset
		c = 8'($urandom);
		wr(uart_chan_pkg::A_SPR, c);
		wr(uart_chan_pkg::A_LCR, ~c);
		wr(uart_chan_pkg::A_DIV_LOW, c ^ 8'h5A);
		wr(uart_chan_pkg::A_FEATURE_CONTROL_REG, c ^ 8'hC3);
		wr(uart_chan_pkg::A_RES1, c);
		mdl[uart_chan_pkg::A_RES1] = 8'h00;
		wr(uart_chan_pkg::A_MCR, 8'h03);
		#1 check({6'h0, o_rts_n, o_dtr_n}, 8'h00, "modem outputs asserted");
		rd_chk(uart_chan_pkg::A_SPR, mdl[uart_chan_pkg::A_SPR]);
		rd_chk(uart_chan_pkg::A_LCR, mdl[uart_chan_pkg::A_LCR]);
		rd_chk(uart_chan_pkg::A_DIV_LOW, mdl[uart_chan_pkg::A_DIV_LOW]);
		rd_chk(uart_chan_pkg::A_FEATURE_CONTROL_REG, mdl[uart_chan_pkg::A_FEATURE_CONTROL_REG]);
		rd_chk(uart_chan_pkg::A_RES1, mdl[uart_chan_pkg::A_RES1]);
		do_reset();
		table_chk();
		$display("Test finished: second reset");
		// Enhanced bits locked until the enable bit is set
		wr(uart_chan_pkg::A_IER, 8'hE1);
		mdl[uart_chan_pkg::A_IER] = 8'h01;
		rd_chk(uart_chan_pkg::A_IER, mdl[uart_chan_pkg::A_IER]);
		wr(uart_chan_pkg::A_EFR, 8'h10);
		wr(uart_chan_pkg::A_IER, 8'hE1);
		rd_chk(uart_chan_pkg::A_IER, mdl[uart_chan_pkg::A_IER]);
		far.pulse_flow(4'h5);
		rd_chk(uart_chan_pkg::A_FLOWST, 8'h00);
		wr(uart_chan_pkg::A_EFR, 8'h1A);
		far.pulse_flow(4'h5);
		wr(uart_chan_pkg::A_EFR, 8'h10);
		rd_chk(uart_chan_pkg::A_FLOWST, 8'h00);
		wr(uart_chan_pkg::A_EFR, 8'h1A);
		far.pulse_flow(4'hA);
		rd_chk(uart_chan_pkg::A_FLOWST, 8'h0A);
		rd_chk(uart_chan_pkg::A_FLOWST, 8'h00);
		$display("Test finished: enhanced and flow");
		// Mode 3 is expected to fall back to 16X
		for (int m = 0; m < 4; m++) begin
			wr(uart_chan_pkg::A_SAMPLE, 8'(m));
			repeat (3) begin
				n = 0;
				for (int i = 0; i < 400; i++) begin
					@(posedge i_sys_clk);
					#1 n += int'(o_bclk_tick === 1'b1);
					if (o_bit_tick === 1'b1) break;
				end
			end
			check(8'(n), 8'(16 >> (m % 3)), "baud ticks per bit");
		end
		$display("Test finished: sampling ratios");
		// Masked event stays quiet, unmasking raises the line, one-write clears it
		c = 8'($urandom);
		wr(uart_chan_pkg::A_INT_MASK, 8'h00);
		far.send_char(c);
		repeat (8) @(posedge i_sys_clk);
		#1 check({7'h0, o_irq}, 8'h00, "masked interrupt");
		rd_chk(uart_chan_pkg::A_INT_STAT, 8'h01);
		wr(uart_chan_pkg::A_INT_MASK, 8'h03);
		#1 check({7'h0, o_irq}, 8'h01, "unmasked interrupt");
		rd_chk(uart_chan_pkg::A_FCR_ISR, 8'h04);
		rd_chk(uart_chan_pkg::A_RX_TX, c);
		far.end_char();
		rd_chk(uart_chan_pkg::A_FCR_ISR, 8'h01);
		wr(uart_chan_pkg::A_INT_STAT, 8'h01);
		#1 check({7'h0, o_irq}, 8'h00, "cleared interrupt");
		// Two sync stages, edge detect and status set, plus one baud clock
		c = 8'($urandom);
		far.send_char(c);
		n = 0;
		while (o_irq !== 1'b1 && n < 20) begin
			@(posedge i_sys_clk);
			#1 n++;
		end
		check(8'(n <= 4 + uart_chan_pkg::STOP_INT_BCLK), 8'h01, "receive interrupt late");
		rd_chk(uart_chan_pkg::A_RX_TX, c);
		far.end_char();
		wr(uart_chan_pkg::A_INT_STAT, 8'h01);
		wr(uart_chan_pkg::A_RX_TX, ~c);
		rd_chk(uart_chan_pkg::A_INT_STAT, 8'h02);
		#1 check({7'h0, o_irq}, 8'h01, "transmit write interrupt");
		wr(uart_chan_pkg::A_INT_STAT, 8'h02);
		#1 check({7'h0, o_irq}, 8'h00, "transmit interrupt cleared");
		$display("Test finished: interrupts");
		// Upper modem status follows the pins after synchronisation
		far.set_pins(4'($urandom));
		repeat (4) @(posedge i_sys_clk);
		rd(uart_chan_pkg::A_MSR, c);
		check({c[7:4], 4'h0}, {~modem_n, 4'h0}, "modem levels");
		$display("Test finished: modem inputs");
		close_out();
	end
endmodule // uart_channel_reset_state_test
